/* File: hw/ubg_divider.sv */
// reloading down counter: one tick out every reload+1 input ticks
// assumes en_i is a clock enable synchronous to clk_i; held high it counts every clock
`timescale 1ns/10ps
module ubg_divider
    import ubg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic en_i,
    input wire logic [7:0] reload_i,
    output logic [7:0] count_o,
    output logic tick_o
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic tick_q;
    wire at_zero = (cnt_q == 8'h00);

    // reload at zero so a divisor change lands at the next period boundary
    assign cnt_d = clear_i ? reload_i
                 : (en_i && at_zero) ? reload_i
                 : en_i ? (cnt_q - 8'h01)
                 : cnt_q;

    // counter and registered tick
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= UBG_DIVISOR_RST;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= en_i && at_zero && !clear_i;
        end
    end

    assign count_o = cnt_q;
    assign tick_o = tick_q;

endmodule : ubg_divider

/* File: hw/ubg_pkg.sv */
// constants, register map and field layout of the bit-rate generator
// assumes a 32-bit classic wishbone slave port with byte addresses
package ubg_pkg;

    // register byte offsets, one aligned word each
    localparam logic [3:0] UBG_OFS_DIVISOR = 4'h0;
    localparam logic [3:0] UBG_OFS_CTRL = 4'h4;
    localparam logic [3:0] UBG_OFS_STATUS = 4'h8;

    // reset values and control register width
    localparam logic [7:0] UBG_DIVISOR_RST = 8'hFF;
    localparam int UBG_CTRL_W = 5;

    // prescaler select codes {prescale_sel_hi, prescale_sel_lo}
    localparam logic [1:0] UBG_SEL_SYS = 2'h0;
    localparam logic [1:0] UBG_SEL_WATCH = 2'h1;
    localparam logic [1:0] UBG_SEL_DIV16 = 2'h2;
    localparam logic [1:0] UBG_SEL_DIV64 = 2'h3;

    // prescaler terminal counts for divide by 16 (n=2) and 64 (n=3)
    localparam logic [5:0] UBG_PRE_MASK16 = 6'h0F;
    localparam logic [5:0] UBG_PRE_TERM64 = 6'h3F;

    // rate ticks per bit: 64 asynchronous, 8 synchronous
    localparam logic [5:0] UBG_BIT_TERM_ASYNC = 6'h3F;
    localparam logic [5:0] UBG_BIT_TERM_SYNC = 6'h07;

    // control register fields, listed from bit 4 down to bit 0
    typedef struct packed {
        logic mp_enable;
        logic sync_mode;
        logic prescale_sel_hi;
        logic prescale_sel_lo;
        logic mp_bit_to_send;
    } ubg_ctrl_t;

    localparam ubg_ctrl_t UBG_CTRL_RST = ubg_ctrl_t'(5'h00);

endpackage : ubg_pkg

/* File: hw/ubg_rate_gen.sv */
// bit-rate generator top: wishbone registers, prescaler, divider, bit counter and mp bit
// assumes wishbone master on clk_i, watch subclock arriving as a synchronous one-cycle tick
`timescale 1ns/10ps
module ubg_rate_gen
    import ubg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic standby_i,
    input wire logic module_standby_i,
    input wire logic watch_mode_i,
    input wire logic sub_mode_i,
    input wire logic watch_tick_i,
    input wire logic tx_active_i,
    output logic rate_tick_o,
    output logic bit_tick_o,
    output logic mp_bit_o
);

    logic [7:0] divisor_q;
    ubg_ctrl_t ctrl_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic [5:0] pre_cnt_q;
    logic half_q;
    logic [5:0] bit_cnt_q;
    logic bit_tick_q;
    logic mp_bit_q;
    logic [7:0] div_count;
    logic rate_tick;
    logic restart_q;

    // bus decode: one-cycle answer, unmapped reads return zero
    wire bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];
    wire hit_div = (wb_adr_i == UBG_OFS_DIVISOR);
    wire hit_ctrl = (wb_adr_i == UBG_OFS_CTRL);
    wire hit_stat = (wb_adr_i == UBG_OFS_STATUS);
    wire wr_div = wr_lane0 && hit_div;
    wire wr_ctrl = wr_lane0 && hit_ctrl;
    // standby-like modes set the divisor to all ones, clear the control, prescaler and bit counter registers and restart the divider
    wire force_init = standby_i || module_standby_i || watch_mode_i;
    wire [1:0] sel = {ctrl_q.prescale_sel_hi, ctrl_q.prescale_sel_lo};

    // read mux
    logic [31:0] rdata_d;
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (hit_div)
            rdata_d = {24'h00_0000, divisor_q};
        else if (hit_ctrl)
            rdata_d = {27'h000_0000, ctrl_q};
        else if (hit_stat)
            rdata_d = {24'h00_0000, div_count};
    end

    // bus handshake and read data
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= bus_req;
            rdata_q <= bus_req ? rdata_d : rdata_q;
        end
    end

    // divisor register: the mode forcing beats a same-cycle write
    always_ff @(posedge clk_i)
    begin
        if (rst_i || force_init)
            divisor_q <= UBG_DIVISOR_RST;
        else if (wr_div)
            divisor_q <= wb_dat_i[7:0];
    end

    // control register holding mp bit, select bits and mode bits
    always_ff @(posedge clk_i)
    begin
        if (rst_i || force_init)
            ctrl_q <= UBG_CTRL_RST;
        else if (wr_ctrl)
            ctrl_q <= ubg_ctrl_t'(wb_dat_i[UBG_CTRL_W-1:0]);
    end

    // prescaler; subclock halved in active/sleep, full in sub modes
    wire pre_tick = (sel == UBG_SEL_SYS) ? 1'b1
                  : (sel == UBG_SEL_DIV16) ? ((pre_cnt_q & UBG_PRE_MASK16) == UBG_PRE_MASK16)
                  : (sel == UBG_SEL_DIV64) ? (pre_cnt_q == UBG_PRE_TERM64)
                  : (watch_tick_i && (sub_mode_i || half_q));

    always_ff @(posedge clk_i)
    begin
        if (rst_i || force_init)
        begin
            pre_cnt_q <= 6'h00;
            half_q <= 1'b0;
        end
        else
        begin
            pre_cnt_q <= pre_cnt_q + 6'h01;
            half_q <= watch_tick_i ? !half_q : half_q;
        end
    end

    // the divisor register holds the new value only one edge after the write,
    // so the divider is cleared once more then to reload the new value, not the old one
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            restart_q <= 1'b0;
        else
            restart_q <= wr_div || force_init;
    end

    // a divisor write restarts the divider so the new rate starts cleanly
    ubg_divider u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(force_init || wr_div || restart_q),
        .en_i(pre_tick),
        .reload_i(divisor_q),
        .count_o(div_count),
        .tick_o(rate_tick)
    );

    // bit counter: 64 rate ticks per async bit, 8 per sync bit
    wire [5:0] bit_term = ctrl_q.sync_mode ? UBG_BIT_TERM_SYNC : UBG_BIT_TERM_ASYNC;
    wire bit_end = rate_tick && (bit_cnt_q >= bit_term);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || force_init || wr_div || restart_q)
        begin
            bit_cnt_q <= 6'h00;
            bit_tick_q <= 1'b0;
        end
        else
        begin
            bit_cnt_q <= bit_end ? 6'h00 : (rate_tick ? bit_cnt_q + 6'h01 : bit_cnt_q);
            bit_tick_q <= bit_end;
        end
    end

    // mp bit only counts in async multiprocessor transmission
    wire mp_valid = !ctrl_q.sync_mode && ctrl_q.mp_enable && tx_active_i;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mp_bit_q <= 1'b0;
        else
            mp_bit_q <= mp_valid && ctrl_q.mp_bit_to_send;
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;
    assign rate_tick_o = rate_tick;
    assign bit_tick_o = bit_tick_q;
    assign mp_bit_o = mp_bit_q;

    property p_mp_follow;
        @(posedge clk_i) disable iff (rst_i)
        mp_valid |=> (mp_bit_o == $past(ctrl_q.mp_bit_to_send));
    endproperty
    a_mp_follow: assert property (p_mp_follow) else $error("mp bit not following control");

    property p_mp_ignored;
        @(posedge clk_i) disable iff (rst_i)
        !mp_valid |=> !mp_bit_o;
    endproperty
    a_mp_ignored: assert property (p_mp_ignored) else $error("mp bit sent while invalid");

    property p_ctrl_reset;
        @(posedge clk_i)
        $past(rst_i) |-> (!ctrl_q.mp_bit_to_send && divisor_q == UBG_DIVISOR_RST);
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset) else $error("reset values wrong");

    property p_div_write;
        @(posedge clk_i) disable iff (rst_i)
        (wr_div && !force_init) |=> (divisor_q == $past(wb_dat_i[7:0])) && wb_ack_o;
    endproperty
    a_div_write: assert property (p_div_write) else $error("divisor write lost");

    property p_force_init;
        @(posedge clk_i) disable iff (rst_i)
        force_init |=> (divisor_q == UBG_DIVISOR_RST) && (ctrl_q == UBG_CTRL_RST);
    endproperty
    a_force_init: assert property (p_force_init) else $error("standby did not reinit");

    property p_ack_once;
        @(posedge clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle");

    property p_pre64;
        @(posedge clk_i) disable iff (rst_i)
        (sel == UBG_SEL_DIV64) && pre_tick |-> (pre_cnt_q == UBG_PRE_TERM64);
    endproperty
    a_pre64: assert property (p_pre64) else $error("divide by 64 tick misplaced");

    property p_sys_div0;
        @(posedge clk_i) disable iff (rst_i || force_init || wr_div)
        (sel == UBG_SEL_SYS) && (divisor_q == 8'h00) && $stable(divisor_q) |=> rate_tick;
    endproperty
    a_sys_div0: assert property (p_sys_div0) else $error("rate tick missing at N=0");

    property p_bit_sync;
        @(posedge clk_i) disable iff (rst_i || force_init || wr_div)
        ctrl_q.sync_mode && rate_tick && (bit_cnt_q == UBG_BIT_TERM_SYNC) |=> bit_tick_o && (bit_cnt_q == 6'h00);
    endproperty
    a_bit_sync: assert property (p_bit_sync) else $error("sync bit tick wrong");

    property p_bit_async;
        @(posedge clk_i) disable iff (rst_i || force_init || wr_div)
        !ctrl_q.sync_mode && rate_tick && (bit_cnt_q < UBG_BIT_TERM_ASYNC) |=> !bit_tick_o;
    endproperty
    a_bit_async: assert property (p_bit_async) else $error("async bit tick early");

endmodule : ubg_rate_gen

/* File: tb/testbench.sv */
// self-checking bench of the bit-rate generator over wishbone
// assumes the line model supplies watch ticks and measures periods
`timescale 1ns/10ps
module testbench;
    import ubg_pkg::*;
    logic clk_i = 0;
    logic rst_i = 1;
    logic cyc = 0;
    logic stb = 0;
    logic we = 0;
    logic sb = 0;
    logic msb = 0;
    logic wm = 0;
    logic sub = 0;
    logic txa = 0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] q;
    wire [31:0] dat;
    wire ack, rtick, btick, mpb, wt;
    int rate_per, bit_per, n_rate, n_bit, n, cycles, n_tests, n_mismatch;
    int pre[5] = '{1, 8, 16, 64, 4};
    always #50 clk_i = ~clk_i;
    ubg_rate_gen dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
        .standby_i(sb), .module_standby_i(msb), .watch_mode_i(wm), .sub_mode_i(sub),
        .watch_tick_i(wt), .tx_active_i(txa), .rate_tick_o(rtick), .bit_tick_o(btick), .mp_bit_o(mpb));
    ubg_line_model line (.clk_i(clk_i), .rst_i(rst_i), .rate_tick_i(rtick), .bit_tick_i(btick),
        .watch_tick_o(wt), .rate_per_o(rate_per), .bit_per_o(bit_per), .n_rate_o(n_rate), .n_bit_o(n_bit));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    // one classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = dat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // skip two ticks so the measured period is a whole one after reconfiguring
    task automatic per(input string what, input int exp, input bit use_bit);
        int n0;
        n0 = use_bit ? n_bit : n_rate;
        wait ((use_bit ? n_bit : n_rate) >= n0 + 3);
        chk(what, exp, use_bit ? bit_per : rate_per);
    endtask : per
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    // hang guard, well above the longest expected run
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial
    begin
        n = $urandom(32'h39A5);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, UBG_OFS_DIVISOR, 0);
        chk("divisor reset", 32'hFF, q);
        wb(0, UBG_OFS_CTRL, 0);
        chk("ctrl reset", 32'h0, q);
        wb(0, 4'hC, 0);
        chk("unmapped read", 32'h0, q);
        $display("reset test done");
        // every prescaler code in sync mode; entry 4 is select 01 in sub mode
        for (int s = 0; s < 5; s++)
        begin
            n = (s == 0) ? 0 : $urandom % 4; // small divisors keep slow prescalers short
            sub <= (s == 4); // sub mode only with half subclock as cpu clock
            wb(1, UBG_OFS_CTRL, 32'h8 | (((s == 4) ? 1 : s) << 1));
            wb(1, UBG_OFS_DIVISOR, n);
            wb(0, UBG_OFS_DIVISOR, 0);
            chk("divisor readback", n, q);
            per("rate period", pre[s] * (n + 1), 0);
        end
        sub <= 1'b0;
        $display("prescaler test done");
        // bit period over system clock, async then sync
        for (int m = 0; m < 2; m++)
        begin
            n = $urandom % 4;
            wb(1, UBG_OFS_CTRL, m << 3);
            wb(1, UBG_OFS_DIVISOR, n);
            per("bit period", (m ? 8 : 64) * (n + 1), 1);
        end
        $display("bit period test done");
        // mp bit over every mix of bit, transmit, sync and enable
        for (int k = 0; k < 16; k++)
        begin
            txa <= k[1];
            wb(1, UBG_OFS_CTRL, (k[3] << 4) | (k[2] << 3) | k[0]);
            repeat (3) @(posedge clk_i);
            chk("mp bit", k[0] & k[1] & ~k[2] & k[3], mpb);
        end
        $display("mp bit test done");
        // each low-power input forces the registers back
        for (int j = 0; j < 3; j++)
        begin
            wb(1, UBG_OFS_DIVISOR, 32'h5);
            wb(1, UBG_OFS_CTRL, 32'h1);
            sb <= (j == 0);
            msb <= (j == 1);
            wm <= (j == 2);
            @(posedge clk_i);
            // while forced the divider keeps reloading all ones
            wb(0, UBG_OFS_STATUS, 0);
            chk("status in standby", 32'hFF, q);
            sb <= 1'b0;
            msb <= 1'b0;
            wm <= 1'b0;
            wb(0, UBG_OFS_DIVISOR, 0);
            chk("divisor forced", 32'hFF, q);
            wb(0, UBG_OFS_CTRL, 0);
            chk("ctrl forced", 32'h0, q);
        end
        $display("standby test done");
        report_and_stop();
    end
endmodule : testbench

/* File: tb/ubg_line_model.sv */
// line-side model: watch subclock source and meter of tick periods
// assumes one clock; periods are counted in clk_i cycles
`timescale 1ns/10ps
module ubg_line_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rate_tick_i,
    input wire logic bit_tick_i,
    output logic watch_tick_o,
    output int rate_per_o,
    output int bit_per_o,
    output int n_rate_o,
    output int n_bit_o
);
    int wc;
    int rc;
    int bc;
    // subclock pulse every fourth clock, so half subclock is eight clocks
    always_ff @(posedge clk_i)
    begin
        wc <= rst_i ? 0 : (wc + 1) % 4;
        watch_tick_o <= !rst_i && wc == 3;
        rc <= rate_tick_i ? 1 : rc + 1;
        bc <= bit_tick_i ? 1 : bc + 1;
        if (rate_tick_i)
        begin
            rate_per_o <= rc;
            n_rate_o <= n_rate_o + 1;
        end
        if (bit_tick_i)
        begin
            bit_per_o <= bc;
            n_bit_o <= n_bit_o + 1;
        end
    end
endmodule : ubg_line_model
